// [src/psrc_top.v]
// peripheral soft reset control: axi4-lite slave and reset outputs
`timescale 1ns/10ps
`default_nettype none
`include "psrc_defs.vh"

module psrc_top #(
   parameter ADDR_W = 12
)
(
   input wire aclk,
   input wire aresetn,
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] capability_mask_two,
   input wire [31:0] capability_mask_four,
   output wire comparator_one_reset,
   output wire comparator_zero_reset,
   output wire gp_counter_two_reset,
   output wire gp_counter_one_reset,
   output wire gp_counter_zero_reset,
   output wire sync_serial_zero_reset,
   output wire async_serial_zero_reset,
   output wire eth_phy_zero_reset,
   output wire eth_mac_zero_reset,
   output wire io_port_a_reset,
   output wire io_port_b_reset,
   output wire io_port_c_reset,
   output wire io_port_d_reset,
   output wire io_port_e_reset,
   output wire io_port_f_reset,
   output wire io_port_g_reset
);

   // write side; address and data may arrive in either order
   localparam [2:0] WR_IDLE = 3'h0;
   localparam [2:0] WR_ADDR = 3'h1;
   localparam [2:0] WR_DATA = 3'h2;
   localparam [2:0] WR_COMMIT = 3'h3;
   localparam [2:0] WR_RESP = 3'h4;

   // read side
   localparam RD_IDLE = 1'h0;
   localparam RD_RESP = 1'h1;

   localparam [ADDR_W-1:0] OFF_ONE = `PSRC_OFF_CTRL_ONE;
   localparam [ADDR_W-1:0] OFF_TWO = `PSRC_OFF_CTRL_TWO;

   reg [2:0] wr_state_q;
   reg [2:0] wr_state_d;
   reg [ADDR_W-1:0] aw_addr_q;
   reg [ADDR_W-1:0] aw_addr_d;
   reg [31:0] w_data_q;
   reg [31:0] w_data_d;
   reg [3:0] w_strb_q;
   reg [3:0] w_strb_d;
   reg [1:0] bresp_q;
   reg [1:0] bresp_d;
   reg rd_state_q;
   reg rd_state_d;
   reg [31:0] rdata_q;
   reg [31:0] rdata_d;
   reg [1:0] rresp_q;
   reg [1:0] rresp_d;

   wire aw_take;
   wire w_take;
   wire do_write;
   wire rd_take;
   wire wr_empty;
   wire wr_have_addr;
   wire wr_have_data;
   wire [ADDR_W-1:0] wr_word;
   wire [ADDR_W-1:0] rd_word;
   wire wr_hit_one;
   wire wr_hit_two;
   wire rd_hit_one;
   wire rd_hit_two;
   wire wr_one;
   wire wr_two;
   wire [31:0] ctrl_one;
   wire [31:0] ctrl_two;
   wire [`PSRC_NUM_PORTS-1:0] port_reset;

   // a channel already held refuses a second beat until the response is accepted
   assign wr_empty = (wr_state_q == WR_IDLE);
   assign wr_have_addr = (wr_state_q == WR_ADDR);
   assign wr_have_data = (wr_state_q == WR_DATA);
   assign s_axi_awready = wr_empty || wr_have_data;
   assign s_axi_wready = wr_empty || wr_have_addr;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign do_write = (wr_state_q == WR_COMMIT);

   assign wr_word = {aw_addr_q[ADDR_W-1:2], 2'b00};
   assign rd_word = {s_axi_araddr[ADDR_W-1:2], 2'b00};
   assign wr_hit_one = (wr_word == OFF_ONE);
   assign wr_hit_two = (wr_word == OFF_TWO);
   assign rd_hit_one = (rd_word == OFF_ONE);
   assign rd_hit_two = (rd_word == OFF_TWO);
   assign wr_one = do_write && wr_hit_one;
   assign wr_two = do_write && wr_hit_two;

   always @*
   begin
      wr_state_d = wr_state_q;
      aw_addr_d = aw_addr_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bresp_d = bresp_q;
      if (aw_take)
      begin
         aw_addr_d = s_axi_awaddr;
      end
      if (w_take)
      begin
         w_data_d = s_axi_wdata;
         w_strb_d = s_axi_wstrb;
      end
      case (wr_state_q)
         WR_IDLE:
         begin
            if (aw_take && w_take)
            begin
               wr_state_d = WR_COMMIT;
            end
            else if (aw_take)
            begin
               wr_state_d = WR_ADDR;
            end
            else if (w_take)
            begin
               wr_state_d = WR_DATA;
            end
         end
         WR_ADDR:
         begin
            if (w_take)
            begin
               wr_state_d = WR_COMMIT;
            end
         end
         WR_DATA:
         begin
            if (aw_take)
            begin
               wr_state_d = WR_COMMIT;
            end
         end
         WR_COMMIT:
         begin
            wr_state_d = WR_RESP;
            // unmapped words answer with an error and change nothing
            if (wr_hit_one || wr_hit_two)
            begin
               bresp_d = `PSRC_RESP_OKAY;
            end
            else
            begin
               bresp_d = `PSRC_RESP_SLVERR;
            end
         end
         WR_RESP:
         begin
            if (s_axi_bready)
            begin
               wr_state_d = WR_IDLE;
            end
         end
         default:
         begin
            wr_state_d = WR_IDLE;
         end
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_state_q <= WR_IDLE;
         aw_addr_q <= {ADDR_W{1'b0}};
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         bresp_q <= `PSRC_RESP_OKAY;
      end
      else
      begin
         wr_state_q <= wr_state_d;
         aw_addr_q <= aw_addr_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         bresp_q <= bresp_d;
      end
   end

   assign s_axi_bvalid = (wr_state_q == WR_RESP);
   assign s_axi_bresp = bresp_q;

   // one read at a time; the live address is decoded at the take edge
   assign s_axi_arready = (rd_state_q == RD_IDLE);
   assign rd_take = s_axi_arvalid && s_axi_arready;

   always @*
   begin
      rd_state_d = rd_state_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      case (rd_state_q)
         RD_IDLE:
         begin
            if (rd_take)
            begin
               rd_state_d = RD_RESP;
               if (rd_hit_one)
               begin
                  rdata_d = ctrl_one;
                  rresp_d = `PSRC_RESP_OKAY;
               end
               else if (rd_hit_two)
               begin
                  rdata_d = ctrl_two;
                  rresp_d = `PSRC_RESP_OKAY;
               end
               else
               begin
                  rdata_d = 32'h00000000;
                  rresp_d = `PSRC_RESP_SLVERR;
               end
            end
         end
         RD_RESP:
         begin
            if (s_axi_rready)
            begin
               rd_state_d = RD_IDLE;
            end
         end
         default:
         begin
            rd_state_d = RD_IDLE;
         end
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_state_q <= RD_IDLE;
         rdata_q <= 32'h00000000;
         rresp_q <= `PSRC_RESP_OKAY;
      end
      else
      begin
         rd_state_q <= rd_state_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   assign s_axi_rvalid = (rd_state_q == RD_RESP);
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // capability masks are live: a unit absent now blocks the write
   psrc_reg #(
      .IMPL_MASK(`PSRC_ONE_IMPL_MASK)
   ) u_ctrl_one (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(wr_one),
      .wr_data(w_data_q),
      .wr_strb(w_strb_q),
      .cap_mask(capability_mask_two),
      .value(ctrl_one)
   );

   psrc_reg #(
      .IMPL_MASK(`PSRC_TWO_IMPL_MASK)
   ) u_ctrl_two (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(wr_two),
      .wr_data(w_data_q),
      .wr_strb(w_strb_q),
      .cap_mask(capability_mask_four),
      .value(ctrl_two)
   );

   // resets are active high levels straight from the register flops
   assign comparator_one_reset = ctrl_one[`PSRC_BIT_COMPARATOR_ONE_RESET];
   assign comparator_zero_reset = ctrl_one[`PSRC_BIT_COMPARATOR_ZERO_RESET];
   assign gp_counter_two_reset = ctrl_one[`PSRC_BIT_GP_COUNTER_TWO_RESET];
   assign gp_counter_one_reset = ctrl_one[`PSRC_BIT_GP_COUNTER_ONE_RESET];
   assign gp_counter_zero_reset = ctrl_one[`PSRC_BIT_GP_COUNTER_ZERO_RESET];
   assign sync_serial_zero_reset = ctrl_one[`PSRC_BIT_SYNC_SERIAL_ZERO_RESET];
   assign async_serial_zero_reset = ctrl_one[`PSRC_BIT_ASYNC_SERIAL_ZERO_RESET];
   assign eth_phy_zero_reset = ctrl_two[`PSRC_BIT_ETH_PHY_ZERO_RESET];
   assign eth_mac_zero_reset = ctrl_two[`PSRC_BIT_ETH_MAC_ZERO_RESET];

   // port resets sit side by side from port a upward
   genvar p;
   generate
      for (p = 0; p < `PSRC_NUM_PORTS; p = p + 1)
      begin : g_port
         assign port_reset[p] = ctrl_two[`PSRC_BIT_PORTA + p];
      end
   endgenerate

   assign io_port_a_reset = port_reset[0];
   assign io_port_b_reset = port_reset[1];
   assign io_port_c_reset = port_reset[2];
   assign io_port_d_reset = port_reset[3];
   assign io_port_e_reset = port_reset[4];
   assign io_port_f_reset = port_reset[5];
   assign io_port_g_reset = port_reset[6];

endmodule
`default_nettype wire

// [common/psrc_defs.vh]
// constants for the peripheral soft reset control block
`ifndef PSRC_DEFS_VH
`define PSRC_DEFS_VH

`define PSRC_OFF_CTRL_ONE 12'h044
`define PSRC_OFF_CTRL_TWO 12'h048
`define PSRC_RESET_VALUE 32'h00000000

`define PSRC_ONE_IMPL_MASK 32'h03070011
`define PSRC_TWO_IMPL_MASK 32'h5000007f

`define PSRC_BIT_COMPARATOR_ONE_RESET 25
`define PSRC_BIT_COMPARATOR_ZERO_RESET 24
`define PSRC_BIT_GP_COUNTER_TWO_RESET 18
`define PSRC_BIT_GP_COUNTER_ONE_RESET 17
`define PSRC_BIT_GP_COUNTER_ZERO_RESET 16
`define PSRC_BIT_SYNC_SERIAL_ZERO_RESET 4
`define PSRC_BIT_ASYNC_SERIAL_ZERO_RESET 0
`define PSRC_BIT_ETH_PHY_ZERO_RESET 30
`define PSRC_BIT_ETH_MAC_ZERO_RESET 28
`define PSRC_BIT_PORTA 0
`define PSRC_NUM_PORTS 7

`define PSRC_RESP_OKAY 2'b00
`define PSRC_RESP_SLVERR 2'b10

`endif

// [src/psrc_reg.v]
// one masked reset control register with byte strobes
`timescale 1ns/10ps
`default_nettype none
`include "psrc_defs.vh"

module psrc_reg #(
   parameter [31:0] IMPL_MASK = 32'h00000000
)
(
   input wire aclk,
   input wire aresetn,
   input wire wr_en,
   input wire [31:0] wr_data,
   input wire [3:0] wr_strb,
   input wire [31:0] cap_mask,
   output wire [31:0] value
);

   reg [31:0] value_q;
   reg [31:0] value_d;
   wire [31:0] lane_mask;
   wire [31:0] write_mask;

   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1)
      begin : g_lane
         assign lane_mask[i*8 +: 8] = {8{wr_strb[i]}};
      end
   endgenerate

   // absent units and reserved bits never take a write
   assign write_mask = lane_mask & cap_mask & IMPL_MASK;

   always @*
   begin
      value_d = value_q;
      if (wr_en)
      begin
         value_d = (value_q & ~write_mask) | (wr_data & write_mask);
      end
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         value_q <= `PSRC_RESET_VALUE;
      end
      else
      begin
         value_q <= value_d;
      end
   end

   // reserved bits read as zero
   assign value = value_q & IMPL_MASK;

endmodule
`default_nettype wire

// [tb/psrc_props.sv]
// bus and unit reset assertions for the reset control block
`timescale 1ns/10ps
`default_nettype none
module psrc_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic comparator_one_reset,
   input wire logic eth_phy_zero_reset,
   input wire logic io_port_a_reset
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   a_ar_ready: assert property (s_axi_arready != s_axi_rvalid)
      else $error("arready wrong");
   a_rd_late: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read late");
   a_rsv_zero: assert property (s_axi_rvalid
      |-> (s_axi_rdata & 32'hacf8ff80) == 32'h0) else $error("reserved set");
   a_b_block: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready) else $error("ready in resp");
   a_wr_late: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write late");
   a_unit_move: assert property ($past(aresetn) && !$stable({
      comparator_one_reset, eth_phy_zero_reset, io_port_a_reset})
      |-> $rose(s_axi_bvalid)) else $error("unit reset moved");
endmodule
bind psrc_top psrc_props psrc_props_i (
   .aclk(aclk),
   .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .comparator_one_reset(comparator_one_reset),
   .eth_phy_zero_reset(eth_phy_zero_reset),
   .io_port_a_reset(io_port_a_reset)
);
`default_nettype wire

// [tb/psrc_top_test.sv]
// self-checking bench for the reset control block
`timescale 1ns/10ps
`default_nettype none
`include "psrc_defs.vh"
module psrc_top_test;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
   logic [31:0] s_axi_wdata = 0, capability_mask_two = 0;
   logic [31:0] capability_mask_four = 0, m1 = 0, m2 = 0;
   logic [3:0] s_axi_wstrb = 0;
   logic [33:0] q[$];
   int bad_count = 0, total_checks = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, comparator_one_reset, comparator_zero_reset;
   wire gp_counter_two_reset, gp_counter_one_reset, gp_counter_zero_reset;
   wire sync_serial_zero_reset, async_serial_zero_reset, eth_phy_zero_reset;
   wire eth_mac_zero_reset, io_port_a_reset, io_port_b_reset;
   wire io_port_c_reset, io_port_d_reset, io_port_e_reset;
   wire io_port_f_reset, io_port_g_reset;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   always #25 aclk = ~aclk;
   psrc_top psrc_top_i (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(s_axi_awprot),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(s_axi_arprot),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .capability_mask_two(capability_mask_two),
      .capability_mask_four(capability_mask_four),
      .comparator_one_reset(comparator_one_reset),
      .comparator_zero_reset(comparator_zero_reset),
      .gp_counter_two_reset(gp_counter_two_reset),
      .gp_counter_one_reset(gp_counter_one_reset),
      .gp_counter_zero_reset(gp_counter_zero_reset),
      .sync_serial_zero_reset(sync_serial_zero_reset),
      .async_serial_zero_reset(async_serial_zero_reset),
      .eth_phy_zero_reset(eth_phy_zero_reset),
      .eth_mac_zero_reset(eth_mac_zero_reset),
      .io_port_a_reset(io_port_a_reset),
      .io_port_b_reset(io_port_b_reset),
      .io_port_c_reset(io_port_c_reset),
      .io_port_d_reset(io_port_d_reset),
      .io_port_e_reset(io_port_e_reset),
      .io_port_f_reset(io_port_f_reset),
      .io_port_g_reset(io_port_g_reset)
   );
   task automatic chk(input logic [33:0] s, input logic [33:0] e);
      total_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("MISMATCH %0t %h %h", $time, s, e);
      end
   endtask
   always @(posedge aclk)
   begin
      if (s_axi_bvalid && s_axi_bready)
         chk({s_axi_bresp, 32'h0}, q.pop_front());
      if (s_axi_rvalid && s_axi_rready)
         chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      logic [31:0] k;
      logic aw, w;
      k = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      // only present, implemented bits of strobed bytes may move
      if (a == `PSRC_OFF_CTRL_ONE)
         m1 = m1 & ~(k & capability_mask_two & `PSRC_ONE_IMPL_MASK)
            | d & k & capability_mask_two & `PSRC_ONE_IMPL_MASK;
      if (a == `PSRC_OFF_CTRL_TWO)
         m2 = m2 & ~(k & capability_mask_four & `PSRC_TWO_IMPL_MASK)
            | d & k & capability_mask_four & `PSRC_TWO_IMPL_MASK;
      q.push_back({(a == `PSRC_OFF_CTRL_ONE || a == `PSRC_OFF_CTRL_TWO)
         ? `PSRC_RESP_OKAY : `PSRC_RESP_SLVERR, 32'h0});
      aw = 0;
      w = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(aw && w))
      begin
         @(posedge aclk);
         aw = aw | s_axi_awready;
         w = w | s_axi_wready;
         s_axi_awvalid <= !aw;
         s_axi_wvalid <= !w;
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [33:0] e);
      q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 0;
      @(posedge aclk);
   endtask
   task units;
      chk({18'h0, comparator_one_reset, comparator_zero_reset,
         gp_counter_two_reset, gp_counter_one_reset, gp_counter_zero_reset,
         sync_serial_zero_reset, async_serial_zero_reset, eth_phy_zero_reset,
         eth_mac_zero_reset, io_port_g_reset, io_port_f_reset,
         io_port_e_reset, io_port_d_reset, io_port_c_reset, io_port_b_reset,
         io_port_a_reset}, {18'h0, m1[25:24], m1[18:16], m1[4], m1[0],
         m2[30], m2[28], m2[6:0]});
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #400000;
      bad_count++;
      stop_test;
   end
   initial
   begin
      void'($urandom(32'h2afe));
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      for (int i = 0; i < 14; i++)
      begin
         // first passes all present, later random capability
         capability_mask_two <= i < 2 ? 32'hffffffff : $urandom;
         capability_mask_four <= i < 2 ? 32'hffffffff : $urandom;
         @(posedge aclk);
         rd(`PSRC_OFF_CTRL_ONE, {`PSRC_RESP_OKAY, m1});
         rd(`PSRC_OFF_CTRL_TWO, {`PSRC_RESP_OKAY, m2});
         wr(`PSRC_OFF_CTRL_ONE, i[0] ? $urandom : '1, 4'($urandom | i));
         wr(`PSRC_OFF_CTRL_TWO, i[0] ? $urandom : '1, 4'($urandom | i));
         units;
         if (i == 6)
         begin
            // stray addresses must answer slverr; a bus reset then clears both registers
            wr(12'h04c, '1, 4'hf);
            rd(12'h040, {`PSRC_RESP_SLVERR, 32'h0});
            aresetn <= 0;
            repeat (2) @(posedge aclk);
            aresetn <= 1;
            m1 = 0;
            m2 = 0;
            @(posedge aclk);
            units;
         end
         $display("test %0d done", i);
      end
      $display("register tests done");
      stop_test;
   end
endmodule
`default_nettype wire
